//--- verilog/timer_core.sv
// Contract
// - edge select 0 disables capture on that channel.
// - edge select 1 captures the running count on each rising input edge.
// - edge select 2 captures on falling edges and 3 on both edges.
// - in continuous mode channel zero matches on equality and still acts as period match for the output logic.
// - in up mode the count clears on the next predivider tick after reaching the period and restarts from 0.
// - in up/down mode the count reverses at the period and again at 0, indefinitely.
// - in up modes period match is count >= period; other channels match on equality.
// - a zero period is invalid in up modes and the timer then stalls once the count reaches 0; software loads nonzero.
// - stop mode halts the count and leaves every control bit unchanged.
// - all channels compare and capture against one shared running count.
// - period match drives the output logic in continuous mode as in the up modes.
// - the timer clock passes a predivider of 1, 2, 4 or 8 before advancing the count.
// - in continuous mode the count steps through 65536 values before repeating.
module timer_core
  import timer_core_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // register port
  input  wire logic [3:0]          regAddr,
  input  wire logic [15:0]         regWdata,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [15:0]         regRdata,
  // capture inputs, one per channel
  input  wire logic [NUM_CH-1:0]   capturePin,
  // compare outputs
  output logic                     periodMatch,
  output logic      [NUM_CH-1:1]   channelMatch,
  output logic      [NUM_CH-1:0]   channelOut,
  // interrupt
  output logic                     irq
);
  import timer_core_pkg::*;

  logic [CNT_W-1:0]  runningCount;
  logic [CNT_W-1:0]  ccr [NUM_CH];
  logic [1:0]        mode;
  logic [1:0]        divSel;
  logic [2:0]        divCnt;
  logic              countDown;
  logic [1:0]        edgeSel [NUM_CH];
  logic              capMode [NUM_CH];
  logic [2:0]        outMode [NUM_CH];
  logic [NUM_CH-1:0] pinPrev;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;

  // capture condition from edge select code
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic now);
    case (sel)
      EDGE_RISE: edge_hit = !prev && now;
      EDGE_FALL: edge_hit = prev && !now;
      EDGE_BOTH: edge_hit = prev != now;
      default:   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // output unit: reaction to own match (x) and to period match (p)
  function automatic logic out_next(input logic [2:0] m, input logic cur, input logic x,
                                    input logic p);
    logic v;
    v = cur;
    if (x) begin
      case (m)
        3'h1, 3'h3: v = 1'b1;
        3'h5, 3'h7: v = 1'b0;
        3'h2, 3'h4, 3'h6: v = ~v;
        default: v = cur;
      endcase
    end
    if (p) begin
      case (m)
        3'h2, 3'h3: v = 1'b0;
        3'h6, 3'h7: v = 1'b1;
        default: v = v;
      endcase
    end
    out_next = v;
  endfunction : out_next

  // predivider: tick every 1, 2, 4 or 8 clocks
  wire [2:0] divMask = 3'((4'h1 << divSel) - 4'h1);
  wire       tick    = (divCnt & divMask) == 3'h0;

  // period compare (>=) only in up modes; continuous matches channel zero on equality
  wire upModes   = (mode == MODE_UP) || (mode == MODE_UPDOWN);
  wire periodHit = upModes ? (runningCount >= ccr[0])
                           : (runningCount == ccr[0]);
  wire periodOk  = ccr[0] != 16'h0000;

  // next count per mode
  logic [CNT_W-1:0] next_count;
  logic             next_down;
  always_comb begin
    next_count = runningCount;
    next_down  = countDown;
    case (mode)
      MODE_CONT:   next_count = runningCount + 16'h0001;
      MODE_UP: begin
        if (periodHit && periodOk)
          next_count = 16'h0000;
        else if (runningCount != 16'h0000 || periodOk)
          next_count = runningCount + 16'h0001;
      end
      MODE_UPDOWN: begin
        if (!periodOk && runningCount == 16'h0000) begin
          next_count = runningCount;
        end else if (!countDown && periodHit && periodOk) begin
          next_down  = 1'b1;
          next_count = runningCount - 16'h0001;
        end else if (countDown && runningCount == 16'h0000) begin
          next_down  = 1'b0;
          next_count = 16'h0001;
        end else if (countDown) begin
          next_count = runningCount - 16'h0001;
        end else begin
          next_count = runningCount + 16'h0001;
        end
      end
      default: next_count = runningCount;
    endcase
  end

  // register decode
  wire       wrCtrl   = regWrite && regAddr == ADDR_CTRL;
  wire       wrStatus = regWrite && regAddr == ADDR_STATUS;
  wire       wrMask   = regWrite && regAddr == ADDR_MASK;
  wire       clrCount = wrCtrl && regWdata[CTRL_CLR_BIT];
  wire       wrapEvt  = tick && mode != MODE_STOP && next_count == 16'h0000
                        && runningCount != 16'h0000;
  wire [2:0] chIdx    = 3'(regAddr - ADDR_CCTL);
  wire [2:0] ccrIdx   = 3'(regAddr - ADDR_PERIOD_COMPARE_REG);
  wire       isCctl   = regAddr >= ADDR_CCTL && regAddr < 4'(ADDR_CCTL + NUM_CH);
  wire       isCcr    = regAddr >= ADDR_PERIOD_COMPARE_REG && regAddr < 4'(ADDR_PERIOD_COMPARE_REG + NUM_CH);

  // predivider counter and running count
  always_ff @(posedge clk) begin
    if (sys_rst || clrCount) begin
      divCnt       <= 3'h0;
      runningCount <= CNT_RESET;
      countDown    <= 1'b0;
    end else if (mode != MODE_STOP) begin
      divCnt <= divCnt + 3'h1;
      if (tick) begin
        runningCount <= next_count;
        countDown    <= next_down;
      end
    end
  end

  // control register; stop mode touches no field but the count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode   <= MODE_STOP;
      divSel <= 2'h0;
      mask   <= '0;
    end else begin
      if (wrCtrl) begin
        mode   <= regWdata[CTRL_MODE_LSB +: 2];
        divSel <= regWdata[CTRL_DIV_LSB +: 2];
      end
      if (wrMask)
        mask <= regWdata[STAT_W-1:0];
    end
  end

  // per-channel compare, capture and output logic
  logic [NUM_CH-1:0] matchNow;
  logic [NUM_CH-1:0] capNow;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      matchNow[i] = !capMode[i] && (i == 0 ? periodHit : runningCount == ccr[i]);
      capNow[i]   = capMode[i] && edge_hit(edgeSel[i], pinPrev[i], capturePin[i]);
    end
  end
  // status and channel output match events fire once per count value, in the cycle after the tick where the count lands
  logic matchArm;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinPrev  <= '0;
      matchArm <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        ccr[i]        <= CCR_RESET;
        edgeSel[i]    <= EDGE_OFF;
        capMode[i]    <= 1'b0;
        outMode[i]    <= 3'h0;
        channelOut[i] <= 1'b0;
      end
    end else begin
      pinPrev  <= capturePin;
      matchArm <= tick && mode != MODE_STOP;
      for (int i = 0; i < NUM_CH; i++) begin
        if (regWrite && isCctl && chIdx == 3'(i)) begin
          edgeSel[i] <= regWdata[CCTL_EDGE_LSB +: 2];
          capMode[i] <= regWdata[CCTL_CAP_BIT];
          outMode[i] <= regWdata[5:3];
        end
        if (capNow[i])
          ccr[i] <= runningCount;
        else if (regWrite && isCcr && ccrIdx == 3'(i))
          ccr[i] <= regWdata;
        if (!capMode[i] && matchArm)
          channelOut[i] <= out_next(outMode[i], channelOut[i],
                                    i != 0 && matchNow[i], matchNow[0]);
      end
    end
  end

  // sticky status, set wins over write-one-to-clear
  wire [STAT_W-1:0] evts = {wrapEvt, (matchNow & {NUM_CH{matchArm}}) | capNow};
  always_ff @(posedge clk) begin
    if (sys_rst)
      status <= '0;
    else
      status <= (status & ~(wrStatus ? regWdata[STAT_W-1:0] : '0)) | evts;
  end

  // match outputs and interrupt, all registered
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periodMatch  <= 1'b0;
      channelMatch <= '0;
      irq          <= 1'b0;
    end else begin
      periodMatch  <= matchNow[0];
      channelMatch <= matchNow[NUM_CH-1:1];
      irq          <= |(status & mask);
    end
  end

  // read mux; unmapped reads return zero
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    if (regAddr == ADDR_CTRL)
      rdMux = {12'h000, divSel, mode};
    else if (regAddr == ADDR_COUNT)
      rdMux = runningCount;
    else if (regAddr == ADDR_STATUS)
      rdMux = {10'h000, status};
    else if (regAddr == ADDR_MASK)
      rdMux = {10'h000, mask};
    else if (isCctl)
      rdMux = {10'h000, outMode[chIdx], capMode[chIdx], edgeSel[chIdx]};
    else if (isCcr)
      rdMux = ccr[ccrIdx];
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      regRdata <= 16'h0000;
    else if (regRead)
      regRdata <= rdMux;
    else
      regRdata <= 16'h0000;
  end

endmodule : timer_core

//--- verilog/timer_core_pkg.sv
package timer_core_pkg;

  // timer modes
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_CONT,
    MODE_UP,
    MODE_UPDOWN
  } timer_mode_t;

  localparam int          CNT_W       = 16;
  localparam int          NUM_CH      = 5;
  // register indices on the plain register port
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_COUNT  = 4'h1;
  localparam logic [3:0]  ADDR_STATUS = 4'h2;
  localparam logic [3:0]  ADDR_MASK   = 4'h3;
  localparam logic [3:0]  ADDR_CCTL   = 4'h4;
  // channel registers start after the five channel control words, so no index is shared
  localparam logic [3:0]  ADDR_PERIOD_COMPARE_REG   = 4'h9;
  // control register fields
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_DIV_LSB  = 2;
  localparam int          CTRL_CLR_BIT  = 4;
  // channel control fields (one word per channel)
  localparam int          CCTL_EDGE_LSB = 0;
  localparam int          CCTL_CAP_BIT  = 2;
  localparam logic [1:0]  EDGE_OFF      = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;
  // status bits: 0..4 channel events, 5 wrap to zero
  localparam int          STAT_WRAP_BIT = 5;
  localparam int          STAT_W        = 6;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [15:0] CCR_RESET     = 16'h0000;

endpackage : timer_core_pkg

//--- bench/timer_core_asserts.sv
module timer_core_asserts
  import timer_core_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // register port
  input wire logic [3:0]        regAddr,
  input wire logic [15:0]       regWdata,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [15:0]       regRdata,
  // events
  input wire logic              periodMatch,
  input wire logic [NUM_CH-1:1] channelMatch,
  input wire logic              irq
);
  logic [1:0]  modeSh;
  logic [1:0]  divSh;
  logic [15:0] perSh;
  logic [15:0] maskSh;
  wire         rdCnt = regRead && regAddr == ADDR_COUNT;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // shadow of software writes; the count is only judged through reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      modeSh <= 2'h0;
      divSh <= 2'h0;
      perSh <= 16'h0000;
      maskSh <= 16'h0000;
    end else if (regWrite) begin
      if (regAddr == ADDR_CTRL) modeSh <= regWdata[CTRL_MODE_LSB+:2];
      if (regAddr == ADDR_CTRL) divSh <= regWdata[CTRL_DIV_LSB+:2];
      if (regAddr == ADDR_PERIOD_COMPARE_REG) perSh <= regWdata;
      if (regAddr == ADDR_MASK) maskSh <= regWdata;
    end
  end

  // two count reads on neighbouring cycles
  sequence s_pair;
    rdCnt ##1 rdCnt;
  endsequence

  property p_rd_idle;
    !$past(regRead) |-> regRdata == 16'h0000;
  endproperty
  property p_cont_step;
    modeSh == MODE_CONT && divSh == 2'h0 ##0 s_pair |=> regRdata == $past(regRdata) + 16'h0001;
  endproperty
  property p_div_step;
    modeSh == MODE_CONT && divSh != 2'h0 ##0 s_pair |=> regRdata - $past(regRdata) <= 16'h0001;
  endproperty
  property p_stop_hold;
    modeSh == MODE_STOP ##0 s_pair |=> $stable(regRdata);
  endproperty
  property p_up_bound;
    modeSh == MODE_UP && perSh != 16'h0000 && rdCnt |=> regRdata <= perSh;
  endproperty
  property p_updn_bound;
    modeSh == MODE_UPDOWN && perSh != 16'h0000 && rdCnt |=> regRdata <= perSh;
  endproperty
  property p_updn_step;
    modeSh == MODE_UPDOWN && divSh == 2'h0 && perSh != 16'h0000 ##0 s_pair
      |=> regRdata == $past(regRdata) + 16'h0001 || regRdata == $past(regRdata) - 16'h0001;
  endproperty
  property p_irq_masked;
    maskSh == 16'h0000 && $past(maskSh) == 16'h0000 |-> !irq;
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_cont_step: assert property (p_cont_step) else $error("count step wrong");
  a_div_step: assert property (p_div_step) else $error("divided step wrong");
  a_stop_hold: assert property (p_stop_hold) else $error("count moved in stop");
  a_up_bound: assert property (p_up_bound) else $error("count above period");
  a_updn_bound: assert property (p_updn_bound) else $error("count above top");
  a_updn_step: assert property (p_updn_step) else $error("up/down step wrong");
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");

  c_irq: cover property (irq);
  c_pmatch: cover property ($rose(periodMatch));
  c_cmatch: cover property (channelMatch[2]);
endmodule : timer_core_asserts

//--- bench/capture_src.sv
module capture_src
  import timer_core_pkg::*;
(
  // clock in, capture levels out
  input wire logic              clk,
  output logic     [NUM_CH-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins move just after an edge so the block samples clean levels
  initial pin = '0;
  task automatic drive(input int ch, input logic v);
    @(posedge clk);
    pin[ch] <= v;
  endtask : drive
endmodule : capture_src

//--- bench/tb_top.sv
module tb_top;
  import timer_core_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [3:0]        regAddr = 4'h0;
  logic [15:0]       regWdata = 16'h0000;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic [15:0]       regRdata;
  logic [NUM_CH-1:0] capturePin;
  logic              periodMatch;
  logic [NUM_CH-1:1] channelMatch;
  logic [NUM_CH-1:0] channelOut;
  logic              irq;
  logic [15:0]       rv [16];
  int                num_errors = 0;
  int                num_checks = 0;

  // 125 MHz
  always #4 clk = ~clk;

  timer_core dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .capturePin(capturePin),
    .periodMatch(periodMatch), .channelMatch(channelMatch), .channelOut(channelOut), .irq(irq));
  capture_src src (.clk(clk), .pin(capturePin));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  // n back-to-back reads; each word is taken in the cycle after its strobe
  task automatic rd(input logic [3:0] a, input int n);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (i == n - 1) regRead <= 1'b0;
      #1 rv[i] = regRdata;
    end
  endtask : rd

  // read gaps are multiples of 8 so every divider phase gives the same step
  task automatic t_cont;
    logic [15:0] c0;
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_CTRL, 16'(d << CTRL_DIV_LSB) | 16'h0011);
      rd(ADDR_COUNT, 2);
      c0 = rv[0];
      repeat (13) @(posedge clk);
      rd(ADDR_COUNT, 2);
      chk("count step", c0 + 16'(16 >> d), rv[0]);
    end
    // back to /1 without clearing, so the full turn takes 65536 clocks
    wr(ADDR_CTRL, 16'h0001);
    rd(ADDR_COUNT, 2);
    c0 = rv[0];
    repeat (65533) @(posedge clk);
    rd(ADDR_COUNT, 2);
    chk("count after full turn", c0, rv[0]);
    wr(ADDR_CTRL, 16'h0000);
    rd(ADDR_COUNT, 2);
    c0 = rv[0];
    repeat (13) @(posedge clk);
    rd(ADDR_COUNT, 2);
    chk("count in stop", c0, rv[0]);
  endtask : t_cont

  task automatic t_period(input timer_mode_t m, input logic [15:0] p);
    logic [15:0] top;
    wr(ADDR_PERIOD_COMPARE_REG, p);
    wr(ADDR_CTRL, 16'h0010 | 16'(m));
    rd(ADDR_COUNT, 16);
    top = 16'h0000;
    for (int i = 0; i < 16; i++) if (rv[i] > top) top = rv[i];
    chk("count peak", p, top);
  endtask : t_period

  // in continuous mode channel zero matches on equality only
  task automatic t_match;
    int h0;
    int h2;
    int ho;
    h0 = 0;
    h2 = 0;
    ho = 0;
    wr(ADDR_PERIOD_COMPARE_REG, 16'h0040);
    wr(ADDR_PERIOD_COMPARE_REG + 4'h2, 16'h0000 + 16'h0030);
    // channel 2 in set/reset: set by its own match, reset by the period match
    wr(ADDR_CCTL + 4'h2, 16'h0018);
    wr(ADDR_CTRL, 16'h0011);
    repeat (200) begin
      @(posedge clk);
      #1 h0 += int'(periodMatch === 1'b1);
      h2 += int'(channelMatch[2] === 1'b1);
      ho += int'(channelOut[2] === 1'b1);
    end
    chk("period match cycles", 16'h0001, 16'(h0));
    chk("channel match cycles", 16'h0001, 16'(h2));
    chk("channel out high cycles", 16'h0010, 16'(ho));
    chk("channel out final", 16'h0000, {15'h0000, channelOut[2]});
  endtask : t_match

  // count held at zero, sentinel in the register shows whether it captured
  task automatic t_capture;
    wr(ADDR_CTRL, 16'h0010);
    wr(ADDR_MASK, 16'h0002);
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_CCTL + 4'h1, 16'h0004 | 16'(e));
      wr(ADDR_STATUS, 16'h003F);
      wr(ADDR_PERIOD_COMPARE_REG + 4'h1, 16'h1234);
      src.drive(1, 1'b1);
      rd(ADDR_PERIOD_COMPARE_REG + 4'h1, 1);
      chk("capture on rise", (e % 2 == 1) ? 16'h0000 : 16'h1234, rv[0]);
      chk("irq after rise", 16'(e % 2), {15'h0000, irq});
      wr(ADDR_PERIOD_COMPARE_REG + 4'h1, 16'h1234);
      src.drive(1, 1'b0);
      rd(ADDR_PERIOD_COMPARE_REG + 4'h1, 1);
      chk("capture on fall", (e >= 2) ? 16'h0000 : 16'h1234, rv[0]);
    end
    rd(ADDR_MASK, 1);
    chk("mask kept in stop", 16'h0002, rv[0]);
    wr(ADDR_MASK, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(ADDR_MASK, 16'h0002);
    repeat (2) @(posedge clk);
    #1 chk("irq pending", 16'h0001, {15'h0000, irq});
    wr(ADDR_STATUS, 16'h0002);
    repeat (2) @(posedge clk);
    #1 chk("irq cleared", 16'h0000, {15'h0000, irq});
  endtask : t_capture

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_cont;
    t_period(MODE_UP, 16'h0005);
    t_period(MODE_UPDOWN, 16'h0006);
    t_period(MODE_UP, 16'h0000);
    t_period(MODE_UPDOWN, 16'h0000);
    t_match;
    t_capture;
    summarize;
  end

  // the full-turn wait dominates the run; this leaves ample margin
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    $display("watchdog expired");
    summarize;
  end
endmodule : tb_top

bind timer_core timer_core_asserts chk_i (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .periodMatch(periodMatch), .channelMatch(channelMatch), .irq(irq));
